// ===== hw/smc_pkg.sv
// constants for the synthesizer and mixer configuration register bank
package smc_pkg;
  localparam int          WORD_W        = 24;
  localparam int          SEL_W         = 3;
  // select codes held in the low three bits of every word
  localparam logic [2:0]  SEL_DITHER    = 3'h3;
  localparam logic [2:0]  SEL_PUMP      = 3'h4;
  localparam logic [2:0]  SEL_LOPATH    = 3'h5;
  localparam logic [2:0]  SEL_VCO       = 3'h6;
  // dither word
  localparam int          DITH_LSB      = 3;
  localparam int          DITH_W        = 17;
  // pump, detector and reference word
  localparam int          MON_SEL_LSB   = 3;
  localparam int          MON_SEL_W     = 3;
  localparam int          REF_SCALE_LSB = 6;
  localparam int          REF_SCALE_W   = 2;
  localparam int          PUMP_MULT_LSB = 10;
  localparam int          PUMP_MULT_W   = 2;
  localparam int          PH_OFS_LSB    = 12;
  localparam int          PH_OFS_W      = 5;
  localparam int          PH_SIGN_BIT   = 17;
  localparam int          CURRENT_SET_RESISTOR_BIT      = 18;
  // lo path word
  localparam int          LO_DRIVE_BIT  = 3;
  localparam int          LO_EXT_BIT    = 4;
  localparam int          PRESC_BIT     = 5;
  localparam int          SYNTH_EN_BIT  = 6;
  localparam int          MIX_BIAS_BIT  = 7;
  localparam int          DISTORTION_COMP_SETTING_LSB      = 8;
  localparam int          DISTORTION_COMP_SETTING_W        = 4;
  // vco word
  localparam int          BAND_LSB      = 3;
  localparam int          BAND_W        = 6;
  localparam int          BAND_SRC_BIT  = 9;
  localparam int          AMP_LSB       = 10;
  localparam int          AMP_W         = 6;
  localparam int          OSC_SW_BIT    = 16;
  localparam int          OSC_ON_BIT    = 17;
  localparam int          OSC_REG_BIT   = 18;
  localparam int          MAIN_REG_BIT  = 19;
  localparam int          PUMP_ON_BIT   = 20;
  // reset values of the four words
  localparam logic [23:0] DITHER_RST    = 24'h000000;
  localparam logic [23:0] PUMP_RST      = 24'h000000;
  localparam logic [23:0] LOPATH_RST    = 24'h000000;
  localparam logic [23:0] VCO_RST       = 24'h000000;
  // base pump current with the internal resistor, microamps
  localparam int          PUMP_BASE_UA  = 250;
  // monitor output choices
  typedef enum logic [2:0] {
    SMC_MON_LOCK = 3'h0,
    SMC_MON_HIGH = 3'h1,
    SMC_MON_LOW  = 3'h2,
    SMC_MON_PUMP = 3'h3,
    SMC_MON_OSC  = 3'h4
  } smc_mon_t;
endpackage

// ===== hw/smc_config_regs.sv
// serial word receiver and configuration registers three to six
`timescale 1ns/100ps
module smc_config_regs (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ser_clk,
  input  wire logic        ser_data,
  input  wire logic        ser_latch,
  input  wire logic        lock_detect,
  input  wire logic [5:0]  cal_band,
  output logic [16:0]      dither_restart,
  output logic             current_set_resistor,
  output logic [2:0]       pump_multiplier,
  output logic [4:0]       phase_offset_multiplier,
  output logic             phase_offset_negative,
  output logic [1:0]       ref_scale,
  output logic             monitor_output,
  output logic             lo_pin_drive,
  output logic             lo_external,
  output logic             presc_div3,
  output logic             synth_on,
  output logic             mixer_bias_on,
  output logic [3:0]       distortion_comp_setting,
  output logic             band_source_select,
  output logic [5:0]       band_in_use,
  output logic [5:0]       osc_amplitude_field,
  output logic             osc_switch_cal,
  output logic             pump_on,
  output logic             main_regulator_on,
  output logic             osc_regulator_on,
  output logic             osc_on
);

  // three-stage samplers on the serial pins and the lock indication
  logic [2:0]  sclk_sync_reg;
  logic [2:0]  sdat_sync_reg;
  logic [2:0]  slat_sync_reg;
  logic [2:0]  lock_sync_reg;
  logic [23:0] shift_reg;
  logic [23:0] shift_next;
  logic [23:0] dither_reg;
  logic [23:0] dither_next;
  logic [23:0] pump_reg;
  logic [23:0] pump_next;
  logic [23:0] lopath_reg;
  logic [23:0] lopath_next;
  logic [23:0] vco_reg;
  logic [23:0] vco_next;
  logic [5:0]  band_reg;
  logic [5:0]  band_next;
  logic [2:0]  mult_reg;
  logic [2:0]  mult_next;
  logic        mon_reg;
  logic        mon_next;
  logic        sclk_rise;
  logic        slat_rise;

  // next values of the pin samplers
  logic [2:0]  sclk_sync_next;
  logic [2:0]  sdat_sync_next;
  logic [2:0]  slat_sync_next;
  logic [2:0]  lock_sync_next;

  // one write strobe per word, at most one high in a cycle
  logic        wr_dither;
  logic        wr_pump;
  logic        wr_lopath;
  logic        wr_vco;

  // a rise counts once stage two is high while stage three is still low
  function automatic logic rose(input logic [2:0] s);
    rose = s[1] & ~s[2];
  endfunction

  // select code of a word, compared once per register below
  function automatic logic [2:0] sel_of(input logic [23:0] w);
    sel_of = w[smc_pkg::SEL_W-1:0];
  endfunction

  // stage one may be metastable, so only stage two onward is read
  always_comb begin
    sclk_sync_next = {sclk_sync_reg[1:0], ser_clk};
    sdat_sync_next = {sdat_sync_reg[1:0], ser_data};
    slat_sync_next = {slat_sync_reg[1:0], ser_latch};
    lock_sync_next = {lock_sync_reg[1:0], lock_detect};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_sync_reg <= 3'h0;
      sdat_sync_reg <= 3'h0;
      slat_sync_reg <= 3'h0;
      lock_sync_reg <= 3'h0;
    end else begin
      sclk_sync_reg <= sclk_sync_next;
      sdat_sync_reg <= sdat_sync_next;
      slat_sync_reg <= slat_sync_next;
      lock_sync_reg <= lock_sync_next;
    end
  end

  assign sclk_rise = rose(sclk_sync_reg);
  assign slat_rise = rose(slat_sync_reg);

  // refused codes raise no strobe, so every word holds
  always_comb begin
    wr_dither = 1'b0;
    wr_pump   = 1'b0;
    wr_lopath = 1'b0;
    wr_vco    = 1'b0;
    if (slat_rise) begin
      if (sel_of(shift_reg) == smc_pkg::SEL_DITHER) begin
        wr_dither = 1'b1;
      end else if (sel_of(shift_reg) == smc_pkg::SEL_PUMP) begin
        wr_pump = 1'b1;
      end else if (sel_of(shift_reg) == smc_pkg::SEL_LOPATH) begin
        wr_lopath = 1'b1;
      end else if (sel_of(shift_reg) == smc_pkg::SEL_VCO) begin
        wr_vco = 1'b1;
      end
    end
  end

  // msb first; the shifter clears only in reset, older bits fall off the top
  always_comb begin
    shift_next = shift_reg;
    if (sclk_rise) begin
      shift_next = {shift_reg[22:0], sdat_sync_reg[1]};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= 24'h000000;
    end else begin
      shift_reg <= shift_next;
    end
  end

  // reserved bits are stored as sent; host keeps them zero
  always_comb begin
    dither_next = dither_reg;
    if (wr_dither) begin
      dither_next = shift_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dither_reg <= smc_pkg::DITHER_RST;
    end else begin
      dither_reg <= dither_next;
    end
  end

  always_comb begin
    pump_next = pump_reg;
    if (wr_pump) begin
      pump_next = shift_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pump_reg <= smc_pkg::PUMP_RST;
    end else begin
      pump_reg <= pump_next;
    end
  end

  always_comb begin
    lopath_next = lopath_reg;
    if (wr_lopath) begin
      lopath_next = shift_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lopath_reg <= smc_pkg::LOPATH_RST;
    end else begin
      lopath_reg <= lopath_next;
    end
  end

  always_comb begin
    vco_next = vco_reg;
    if (wr_vco) begin
      vco_next = shift_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vco_reg <= smc_pkg::VCO_RST;
    end else begin
      vco_reg <= vco_next;
    end
  end

  // derived outputs, registered so every port leaves a flop
  // own flop so the multiplier resets to one, never zero
  always_comb begin
    mult_next = {1'b0, pump_next[smc_pkg::PUMP_MULT_LSB +: smc_pkg::PUMP_MULT_W]}
              + 3'h1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mult_reg <= 3'h1;
    end else begin
      mult_reg <= mult_next;
    end
  end

  // tracks the word being written, so no extra cycle of lag
  always_comb begin
    if (vco_next[smc_pkg::BAND_SRC_BIT]) begin
      band_next = vco_next[smc_pkg::BAND_LSB +: smc_pkg::BAND_W];
    end else begin
      band_next = cal_band;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      band_reg <= 6'h00;
    end else begin
      band_reg <= band_next;
    end
  end

  // a flop after the mux keeps the pin free of decode glitches
  always_comb begin
    case (smc_pkg::smc_mon_t'(pump_reg[smc_pkg::MON_SEL_LSB +: smc_pkg::MON_SEL_W]))
      smc_pkg::SMC_MON_LOCK: mon_next = lock_sync_reg[2];
      smc_pkg::SMC_MON_HIGH: mon_next = 1'b1;
      smc_pkg::SMC_MON_LOW:  mon_next = 1'b0;
      smc_pkg::SMC_MON_PUMP: mon_next = vco_reg[smc_pkg::PUMP_ON_BIT];
      smc_pkg::SMC_MON_OSC:  mon_next = vco_reg[smc_pkg::OSC_ON_BIT];
      default:               mon_next = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mon_reg <= 1'b0;
    end else begin
      mon_reg <= mon_next;
    end
  end

  // word fields are wired straight from the word flops; multiplier, monitor and band come from their own flops
  assign dither_restart          = dither_reg[smc_pkg::DITH_LSB +: smc_pkg::DITH_W];

  assign current_set_resistor    = pump_reg[smc_pkg::CURRENT_SET_RESISTOR_BIT];
  assign pump_multiplier         = mult_reg;
  // offset is 22.5 deg times this field over the multiplier
  assign phase_offset_multiplier = pump_reg[smc_pkg::PH_OFS_LSB +: smc_pkg::PH_OFS_W];
  assign phase_offset_negative   = pump_reg[smc_pkg::PH_SIGN_BIT];
  // 0: x2, 1: x1, 2: x0.5, 3: x0.25
  assign ref_scale               = pump_reg[smc_pkg::REF_SCALE_LSB +: smc_pkg::REF_SCALE_W];
  assign monitor_output          = mon_reg;

  assign lo_pin_drive            = lopath_reg[smc_pkg::LO_DRIVE_BIT];
  assign lo_external             = lopath_reg[smc_pkg::LO_EXT_BIT];
  assign presc_div3              = lopath_reg[smc_pkg::PRESC_BIT];
  // host may clear only with a stable external LO present
  assign synth_on                = lopath_reg[smc_pkg::SYNTH_EN_BIT];
  assign mixer_bias_on           = lopath_reg[smc_pkg::MIX_BIAS_BIT];
  assign distortion_comp_setting = lopath_reg[smc_pkg::DISTORTION_COMP_SETTING_LSB +: smc_pkg::DISTORTION_COMP_SETTING_W];

  assign band_source_select      = vco_reg[smc_pkg::BAND_SRC_BIT];
  assign band_in_use             = band_reg;
  assign osc_amplitude_field     = vco_reg[smc_pkg::AMP_LSB +: smc_pkg::AMP_W];
  assign osc_switch_cal          = vco_reg[smc_pkg::OSC_SW_BIT];
  assign pump_on                 = vco_reg[smc_pkg::PUMP_ON_BIT];
  assign main_regulator_on       = vco_reg[smc_pkg::MAIN_REG_BIT];
  assign osc_regulator_on        = vco_reg[smc_pkg::OSC_REG_BIT];
  assign osc_on                  = vco_reg[smc_pkg::OSC_ON_BIT];

endmodule

// ===== tb/smc_host_model.sv
// host side serial word writer for the configuration bank
`timescale 1ns/100ps
module smc_host_model (
  input  wire logic clk,
  output logic      ser_clk,
  output logic      ser_data,
  output logic      ser_latch
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_latch = 1'b0;
  end
  // four clk per level so the pin synchroniser never misses one
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      @(negedge clk) ser_data = w[i];
      repeat (4) @(negedge clk);
      ser_clk = 1'b1;
      repeat (4) @(negedge clk);
      ser_clk = 1'b0;
    end
    repeat (4) @(negedge clk);
    ser_latch = 1'b1;
    ser_data = ~ser_data;
    repeat (4) @(negedge clk);
    ser_latch = 1'b0;
  endtask
endmodule

// ===== tb/smc_config_regs_props.sv
// assertions on the configuration register bank ports
`timescale 1ns/100ps
module smc_config_regs_props (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       ser_latch,
  input wire logic [5:0] cal_band,
  input wire logic [16:0] dither_restart,
  input wire logic [2:0] pump_multiplier,
  input wire logic [4:0] phase_offset_multiplier,
  input wire logic [3:0] distortion_comp_setting,
  input wire logic       synth_on,
  input wire logic       band_source_select,
  input wire logic [5:0] band_in_use,
  input wire logic [5:0] osc_amplitude_field,
  input wire logic       pump_on
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_mult_range: assert property (pump_multiplier inside {[3'h1:3'h4]})
    else $error("pump multiplier out of range");
  chk_reset_vals: assert property (disable iff (1'b0) !rst_n ##1 !rst_n |->
    pump_multiplier == 3'h1 && dither_restart == 17'h0 && !pump_on)
    else $error("bad value in reset");
  chk_band_follow: assert property ($past(rst_n) && !band_source_select
    && !$past(band_source_select) |-> band_in_use == $past(cal_band))
    else $error("band does not follow calibration");
  chk_band_hold: assert property ((!ser_latch) [*8] ##0 band_source_select
    |=> $stable(band_in_use)) else $error("programmed band moved");
  chk_hold_words: assert property ((!ser_latch) [*8] |=> $stable({dither_restart,
    pump_multiplier, phase_offset_multiplier, synth_on})) else $error("field moved idle");
  chk_dither_only: assert property ($changed(dither_restart) |->
    $stable({pump_multiplier, distortion_comp_setting, osc_amplitude_field}))
    else $error("dither write touched others");
  chk_lo_only: assert property ($changed(distortion_comp_setting) |->
    $stable({dither_restart, osc_amplitude_field, pump_multiplier}))
    else $error("lo path write touched others");
  chk_vco_only: assert property ($changed(osc_amplitude_field) |->
    $stable({dither_restart, phase_offset_multiplier})) else $error("vco write touched others");
  cover property ($changed(dither_restart));
  cover property ($rose(pump_on));
  cover property (band_source_select && $changed(cal_band));
endmodule
bind smc_config_regs smc_config_regs_props smc_config_regs_props_i (.clk, .rst_n, .ser_latch,
  .cal_band, .dither_restart, .pump_multiplier, .phase_offset_multiplier,
  .distortion_comp_setting, .synth_on, .band_source_select, .band_in_use,
  .osc_amplitude_field, .pump_on);

// ===== tb/smc_config_regs_tb_top.sv
// self-checking bench for the configuration register bank
`timescale 1ns/100ps
module smc_config_regs_tb_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        lock_detect = 1'b0;
  logic [5:0]  cal_band = 6'h0;
  wire logic   ser_clk, ser_data, ser_latch;
  logic [16:0] dither_restart;
  logic [2:0]  pump_multiplier;
  logic [4:0]  phase_offset_multiplier;
  logic [1:0]  ref_scale;
  logic [3:0]  distortion_comp_setting;
  logic [5:0]  band_in_use, osc_amplitude_field;
  logic        current_set_resistor, phase_offset_negative, monitor_output, lo_pin_drive;
  logic        lo_external, presc_div3, synth_on, mixer_bias_on, band_source_select;
  logic        osc_switch_cal, pump_on, main_regulator_on, osc_regulator_on, osc_on;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  logic [23:0] rows [11] = '{24'h000003, 24'h00000b, 24'h0ffffb, 24'h0000c4, 24'h000444,
    24'h000884, 24'h07fc04, 24'h000a55, 24'h000ffd, 24'h00a80e, 24'h1ffffe};
  always #10 clk = ~clk;
  smc_host_model smc_host_model_i (.clk(clk), .ser_clk(ser_clk), .ser_data(ser_data),
    .ser_latch(ser_latch));
  smc_config_regs smc_config_regs_i (.clk, .rst_n, .ser_clk, .ser_data, .ser_latch,
    .lock_detect, .cal_band, .dither_restart, .current_set_resistor, .pump_multiplier,
    .phase_offset_multiplier, .phase_offset_negative, .ref_scale, .monitor_output,
    .lo_pin_drive, .lo_external, .presc_div3, .synth_on, .mixer_bias_on,
    .distortion_comp_setting, .band_source_select, .band_in_use, .osc_amplitude_field,
    .osc_switch_cal, .pump_on, .main_regulator_on, .osc_regulator_on, .osc_on);
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic put(input logic [23:0] w);
    smc_host_model_i.send(w);
    repeat (8) @(negedge clk);
  endtask
  task automatic check_word(input logic [23:0] w);
    case (w[2:0])
      3'h3: chk(dither_restart, w[19:3]);
      3'h4: chk({current_set_resistor, phase_offset_negative, phase_offset_multiplier,
        pump_multiplier, ref_scale}, {w[18:12], {1'b0, w[11:10]} + 3'h1, w[7:6]});
      3'h5: chk({distortion_comp_setting, mixer_bias_on, synth_on, presc_div3, lo_external,
        lo_pin_drive}, w[11:3]);
      default: chk({pump_on, main_regulator_on, osc_regulator_on, osc_on, osc_switch_cal,
        osc_amplitude_field, band_source_select, band_in_use},
        {w[20:9], w[9] ? w[8:3] : cal_band});
    endcase
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up;
    end
  end
  initial begin
    repeat (8) @(negedge clk);
    chk({pump_multiplier, band_in_use, dither_restart[0]}, {3'h1, 6'h0, 1'b0});
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    cal_band = 6'h2a;
    lock_detect = 1'b1;
    repeat (8) @(negedge clk);
    chk(monitor_output, 1'b1);
    lock_detect = 1'b0;
    repeat (8) @(negedge clk);
    chk(monitor_output, 1'b0);
    $display("test reset and monitor default done");
    foreach (rows[i]) begin
      put(rows[i]);
      check_word(rows[i]);
    end
    $display("test row table done");
    // upper bits set on purpose: refused words must leave every register alone
    cal_band = 6'h15;
    for (int c = 0; c < 4; c++) put(24'hfffff8 | 24'(c == 3 ? 7 : c));
    foreach (rows[i]) if (i == 2 || i == 6 || i == 8 || i == 10) check_word(rows[i]);
    $display("test refused codes done");
    // last vco word left pump and oscillator on; mode 2 and unused 5 read low
    for (int m = 1; m <= 5; m++) begin
      put(24'h000004 | 24'(m << 3));
      chk(monitor_output, m != 2 && m != 5);
    end
    // pump on, oscillator off, band back on calibration: modes 3 and 4 now differ
    put(24'h100006);
    check_word(24'h100006);
    put(24'h000024);
    chk(monitor_output, 1'b0);
    put(24'h00001c);
    chk(monitor_output, 1'b1);
    $display("test monitor modes done");
    // reset in mid-run: every word back to zero, monitor back on lock
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    chk({pump_multiplier, dither_restart, pump_on, monitor_output}, {3'h1, 17'h0, 2'h0});
    chk(band_in_use, 6'h00);
    rst_n = 1'b1;
    lock_detect = 1'b1;
    repeat (8) @(negedge clk);
    chk({monitor_output, band_in_use}, {1'b1, 6'h15});
    $display("test mid-run reset done");
    wrap_up;
  end
endmodule
